// ==== src/adcc_map.vh ====
// Register map, field positions and timing counts of the converter control
`ifndef ADCC_MAP_VH
`define ADCC_MAP_VH

// ==========================================================================
// Register offsets (byte addresses on the register port)
`define ADCC_OFS_MAIN    8'h00
`define ADCC_OFS_ACCUM   8'h01
`define ADCC_OFS_REFCLK  8'h02
`define ADCC_OFS_DELAY   8'h03
`define ADCC_OFS_WINDOW  8'h04
`define ADCC_OFS_CMD     8'h08
`define ADCC_OFS_FLAGS   8'h0B
`define ADCC_OFS_RESLO   8'h10
`define ADCC_OFS_RESHI   8'h11

// ==========================================================================
// Reset value and writable-bit masks
`define ADCC_RST_CTRL    8'h00
`define ADCC_MSK_MAIN    8'h87
`define ADCC_MSK_ACCUM   8'h07
`define ADCC_MSK_REFCLK  8'h77
`define ADCC_MSK_DELAY   8'hFF
`define ADCC_MSK_WINDOW  8'h07

// ==========================================================================
// Field positions
`define ADCC_BIT_ENABLE  0
`define ADCC_BIT_FREE_RUNNING 1
`define ADCC_BIT_RESOLUTION_SELECT  2
`define ADCC_BIT_RUN_IN_STANDBY 7
`define ADCC_BIT_CAPSEL  6
`define ADCC_BIT_AUTODLY 4
`define ADCC_BIT_START   0
`define ADCC_BIT_RDY     0
`define ADCC_BIT_WIN     1

// ==========================================================================
// Reference and window-compare codes
`define ADCC_REF_INTERNAL 2'h0
`define ADCC_REF_SUPPLY   2'h1
`define ADCC_WIN_BELOW    3'h1
`define ADCC_WIN_ABOVE    3'h2
`define ADCC_WIN_INSIDE   3'h3
`define ADCC_WIN_OUTSIDE  3'h4

// ==========================================================================
// Start-up delays in converter-clock cycles
`define ADCC_INIT_DLY0   9'h000
`define ADCC_INIT_DLY16  9'h010
`define ADCC_INIT_DLY32  9'h020
`define ADCC_INIT_DLY64  9'h040
`define ADCC_INIT_DLY128 9'h080
`define ADCC_INIT_DLY256 9'h100

`endif

// ==== src/adcc_conversion_control.v ====
// Conversion sequencer and control registers of the 10-bit converter
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`include "adcc_map.vh"
`default_nettype none

module adcc_conversion_control
(
    // Clock and reset
    input  wire        clk,
    input  wire        rst,
    // Register port
    input  wire [7:0]  regAddr,
    input  wire [7:0]  regWdata,
    input  wire        regWrite,
    input  wire        regRead,
    output reg  [7:0]  regRdata,
    // Sleep controller
    input  wire        standbySleep,
    input  wire        deepWake,
    // Window thresholds
    input  wire [15:0] windowLow,
    input  wire [15:0] windowHigh,
    // Analog core
    input  wire        coreDone,
    input  wire [9:0]  coreData,
    output reg         coreStart,
    output reg         sampleSwitchClosed,
    output reg         converterTick,
    output reg         converterActive,
    output reg  [1:0]  referenceSelect,
    output reg         sampleCapReduced,
    // Status
    output reg         resultReady,
    output reg         windowMatch,
    output reg  [15:0] resultValue
);

    // ======================================================================
    // States
    localparam [3:0] ST_IDLE  = 4'h1;
    localparam [3:0] ST_INIT  = 4'h2;
    localparam [3:0] ST_DELAY = 4'h4;
    localparam [3:0] ST_CONV  = 4'h8;

    // ======================================================================
    // Declarations
    reg  [7:0]  ctrlMain;
    reg  [7:0]  ctrlAccum;
    reg  [7:0]  ctrlRefClk;
    reg  [7:0]  ctrlDelay;
    reg  [7:0]  ctrlWindow;
    reg  [3:0]  state;
    reg  [7:0]  presCnt;
    reg  [8:0]  initCnt;
    reg  [3:0]  delayCnt;
    reg  [6:0]  samplesLeft;
    reg  [15:0] accum;
    reg         initPending;
    reg         enablePrev;
    reg         doneEvt;
    reg  [6:0]  sampleTarget;
    reg  [8:0]  initLen;
    reg         winHit;
    wire        enable;
    wire        active;
    wire        tick;
    wire [8:0]  presDiv;
    wire [7:0]  presMax;
    wire [15:0] sampleVal;
    wire [15:0] finalSum;
    wire        sampleDone;
    wire        lastSample;
    wire        startReq;
    wire        resRead;
    wire        wrFlags;
    wire        refToInternal;

    // ======================================================================
    // Enable and standby gating
    assign enable = ctrlMain[`ADCC_BIT_ENABLE];
    assign active = enable &&
        (!standbySleep || ctrlMain[`ADCC_BIT_RUN_IN_STANDBY]);

    // ======================================================================
    // Prescaler; counter compares with >= so a smaller divisor takes hold
    // at once instead of wrapping through 256 cycles
    assign presDiv = 9'h002 << ctrlRefClk[2:0];
    assign presMax = presDiv[7:0] - 8'h01;
    assign tick    = (presCnt >= presMax);

    always @(posedge clk)
    begin
        if (rst || !active)
            presCnt <= 8'h00;
        else if (tick)
            presCnt <= 8'h00;
        else
            presCnt <= presCnt + 8'h01;
    end

    // ======================================================================
    // Decoders for accumulation count and start-up delay
    always @*
    begin
        case (ctrlAccum[2:0])
            3'h1:    sampleTarget = 7'h02;
            3'h2:    sampleTarget = 7'h04;
            3'h3:    sampleTarget = 7'h08;
            3'h4:    sampleTarget = 7'h10;
            3'h5:    sampleTarget = 7'h20;
            3'h6:    sampleTarget = 7'h40;
            default: sampleTarget = 7'h01;  // Reserved acts as single
        endcase
    end

    // Reserved start-up codes take the longest delay, the safe side
    always @*
    begin
        case (ctrlDelay[7:5])
            3'h0:    initLen = `ADCC_INIT_DLY0;
            3'h1:    initLen = `ADCC_INIT_DLY16;
            3'h2:    initLen = `ADCC_INIT_DLY32;
            3'h3:    initLen = `ADCC_INIT_DLY64;
            3'h4:    initLen = `ADCC_INIT_DLY128;
            default: initLen = `ADCC_INIT_DLY256;
        endcase
    end

    // ======================================================================
    // Sample shaping and accumulation sum
    assign sampleVal = ctrlMain[`ADCC_BIT_RESOLUTION_SELECT] ?
        {8'h00, coreData[9:2]} :
        {6'h00, coreData};
    assign finalSum   = accum + sampleVal;
    assign sampleDone = (state == ST_CONV) && coreDone;
    assign lastSample = (samplesLeft == 7'h01);

    // ======================================================================
    // Window comparison on the completed sum
    always @*
    begin
        case (ctrlWindow[2:0])
            `ADCC_WIN_BELOW:   winHit = (finalSum < windowLow);
            `ADCC_WIN_ABOVE:   winHit = (finalSum > windowHigh);
            `ADCC_WIN_INSIDE:  winHit = (finalSum > windowLow) &&
                                        (finalSum < windowHigh);
            `ADCC_WIN_OUTSIDE: winHit = (finalSum < windowLow) ||
                                        (finalSum > windowHigh);
            default:           winHit = 1'b0;
        endcase
    end

    // ======================================================================
    // Bus decode strobes
    assign startReq = regWrite && (regAddr == `ADCC_OFS_CMD) &&
        regWdata[`ADCC_BIT_START] && active &&
        (state == ST_IDLE);
    assign resRead  = regRead && ((regAddr == `ADCC_OFS_RESLO) ||
        (regAddr == `ADCC_OFS_RESHI));
    assign wrFlags  = regWrite && (regAddr == `ADCC_OFS_FLAGS);
    assign refToInternal = regWrite && (regAddr == `ADCC_OFS_REFCLK) &&
        (regWdata[5:4] == `ADCC_REF_INTERNAL) &&
        (ctrlRefClk[5:4] != `ADCC_REF_INTERNAL);

    // ======================================================================
    // Control registers; software write wins over the auto increment
    always @(posedge clk)
    begin
        if (rst)
        begin
            ctrlMain   <= `ADCC_RST_CTRL;
            ctrlAccum  <= `ADCC_RST_CTRL;
            ctrlRefClk <= `ADCC_RST_CTRL;
            ctrlDelay  <= `ADCC_RST_CTRL;
            ctrlWindow <= `ADCC_RST_CTRL;
        end
        else
        begin
            if (regWrite && (regAddr == `ADCC_OFS_MAIN))
                ctrlMain <= regWdata & `ADCC_MSK_MAIN;
            if (regWrite && (regAddr == `ADCC_OFS_ACCUM))
                ctrlAccum <= regWdata & `ADCC_MSK_ACCUM;
            if (regWrite && (regAddr == `ADCC_OFS_REFCLK))
                ctrlRefClk <= regWdata & `ADCC_MSK_REFCLK;
            if (regWrite && (regAddr == `ADCC_OFS_WINDOW))
                ctrlWindow <= regWdata & `ADCC_MSK_WINDOW;
            if (regWrite && (regAddr == `ADCC_OFS_DELAY))
                ctrlDelay <= regWdata & `ADCC_MSK_DELAY;
            else if (sampleDone && ctrlDelay[`ADCC_BIT_AUTODLY])
                ctrlDelay[3:0] <= ctrlDelay[3:0] + 4'h1;
        end
    end

    // ======================================================================
    // Start-up delay request; a new cause in the consuming cycle wins
    always @(posedge clk)
    begin
        if (rst)
        begin
            enablePrev  <= 1'b0;
            initPending <= 1'b0;
        end
        else
        begin
            enablePrev <= enable;
            if ((enable && !enablePrev) || refToInternal || deepWake)
                initPending <= 1'b1;
            else if (startReq)
                initPending <= 1'b0;
        end
    end

    // ======================================================================
    // Conversion sequencer
    always @(posedge clk)
    begin
        if (rst || !active)
        begin
            state       <= ST_IDLE;
            initCnt     <= 9'h000;
            delayCnt    <= 4'h0;
            samplesLeft <= 7'h00;
            accum       <= 16'h0000;
            coreStart   <= 1'b0;
            doneEvt     <= 1'b0;
        end
        else
        begin
            coreStart <= 1'b0;
            doneEvt   <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    if (startReq)
                    begin
                        accum       <= 16'h0000;
                        samplesLeft <= sampleTarget;
                        if (initPending && (initLen != 9'h000))
                        begin
                            state   <= ST_INIT;
                            initCnt <= initLen;
                        end
                        else
                        begin
                            state     <= ST_CONV;
                            coreStart <= 1'b1;
                        end
                    end
                end
                ST_INIT:
                begin
                    if (tick)
                    begin
                        if (initCnt == 9'h001)
                        begin
                            state     <= ST_CONV;
                            coreStart <= 1'b1;
                        end
                        else
                            initCnt <= initCnt - 9'h001;
                    end
                end
                ST_DELAY:
                begin
                    if (tick)
                    begin
                        if (delayCnt == 4'h1)
                        begin
                            state     <= ST_CONV;
                            coreStart <= 1'b1;
                        end
                        else
                            delayCnt <= delayCnt - 4'h1;
                    end
                end
                ST_CONV:
                begin
                    if (coreDone)
                    begin
                        if (lastSample)
                        begin
                            doneEvt     <= 1'b1;
                            accum       <= 16'h0000;
                            samplesLeft <= sampleTarget;
                        end
                        else
                        begin
                            accum       <= finalSum;
                            samplesLeft <= samplesLeft - 7'h01;
                        end
                        if (lastSample &&
                            !ctrlMain[`ADCC_BIT_FREE_RUNNING])
                            state <= ST_IDLE;
                        else if (ctrlDelay[3:0] == 4'h0)
                        begin
                            state     <= ST_CONV;
                            coreStart <= 1'b1;
                        end
                        else
                        begin
                            state    <= ST_DELAY;
                            delayCnt <= ctrlDelay[3:0];
                        end
                    end
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // ======================================================================
    // Result capture
    always @(posedge clk)
    begin
        if (rst)
            resultValue <= 16'h0000;
        else if (sampleDone && lastSample)
            resultValue <= finalSum;
    end

    // ======================================================================
    // Flags; setting beats a same-cycle clear so no completion is lost
    always @(posedge clk)
    begin
        if (rst)
        begin
            resultReady <= 1'b0;
            windowMatch <= 1'b0;
        end
        else
        begin
            if (sampleDone && lastSample)
                resultReady <= 1'b1;
            else if (resRead || (wrFlags && regWdata[`ADCC_BIT_RDY]))
                resultReady <= 1'b0;
            if (sampleDone && lastSample && winHit)
                windowMatch <= 1'b1;
            else if (resRead || (wrFlags && regWdata[`ADCC_BIT_WIN]))
                windowMatch <= 1'b0;
        end
    end

    // ======================================================================
    // Core-facing levels, all registered
    always @(posedge clk)
    begin
        if (rst)
        begin
            converterTick      <= 1'b0;
            converterActive    <= 1'b0;
            referenceSelect    <= `ADCC_REF_INTERNAL;
            sampleCapReduced   <= 1'b0;
            sampleSwitchClosed <= 1'b0;
        end
        else
        begin
            converterTick    <= active && tick;
            converterActive  <= active;
            referenceSelect  <= ctrlRefClk[5:4];
            sampleCapReduced <= ctrlRefClk[`ADCC_BIT_CAPSEL];
            // Open in every state but an ongoing sample
            sampleSwitchClosed <= active && (state == ST_CONV) &&
                !coreDone;
        end
    end

    // ======================================================================
    // Read port; unmapped addresses read zero
    always @(posedge clk)
    begin
        if (rst)
            regRdata <= 8'h00;
        else if (regRead)
        begin
            if (regAddr == `ADCC_OFS_MAIN)
                regRdata <= ctrlMain;
            else if (regAddr == `ADCC_OFS_ACCUM)
                regRdata <= ctrlAccum;
            else if (regAddr == `ADCC_OFS_REFCLK)
                regRdata <= ctrlRefClk;
            else if (regAddr == `ADCC_OFS_DELAY)
                regRdata <= ctrlDelay;
            else if (regAddr == `ADCC_OFS_WINDOW)
                regRdata <= ctrlWindow;
            else if (regAddr == `ADCC_OFS_CMD)
                regRdata <= {7'h00, (state != ST_IDLE)};
            else if (regAddr == `ADCC_OFS_FLAGS)
                regRdata <= {6'h00, windowMatch, resultReady};
            else if (regAddr == `ADCC_OFS_RESLO)
                regRdata <= resultValue[7:0];
            else if (regAddr == `ADCC_OFS_RESHI)
                regRdata <= resultValue[15:8];
            else
                regRdata <= 8'h00;
        end
        else
            regRdata <= 8'h00;
    end

endmodule

`default_nettype wire

// ==== tb/adcc_conversion_control_chk.sv ====
// Port-level assertions of the converter control block
`timescale 1ns/1ps
`include "adcc_map.vh"
`default_nettype none
module adcc_conversion_control_chk
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // Register port
    input wire logic [7:0]  regAddr,
    input wire logic [7:0]  regWdata,
    input wire logic        regWrite,
    input wire logic        regRead,
    // Analog core and status
    input wire logic        coreDone,
    input wire logic        coreStart,
    input wire logic        sampleSwitchClosed,
    input wire logic        converterTick,
    input wire logic        converterActive,
    input wire logic        resultReady,
    input wire logic [15:0] resultValue
);
    // ==================================================================
    // One clock domain, so one default clocking and disable
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Divided clock pulses stay apart even at divide by two
    AST_TICK_PULSE:
        assert property (converterTick |=> !converterTick)
        else $error("tick longer than one cycle");
    // No tick and no sample while the converter is off
    AST_TICK_IDLE:
        assert property (!converterActive && !$past(converterActive)
            |-> !converterTick)
        else $error("tick while inactive");
    AST_START_IDLE:
        assert property (!converterActive && !$past(converterActive)
            |-> !coreStart)
        else $error("sample started while inactive");
    // A sample starts only with the switch open, and closes it next
    AST_START_OPEN:
        assert property (coreStart |-> !sampleSwitchClosed)
        else $error("start while switch closed");
    AST_SWITCH_CLOSE:
        assert property (coreStart && converterActive
            |=> sampleSwitchClosed || !converterActive)
        else $error("switch did not close after start");
    // Switch opens only at the end of a sample or on abort
    AST_SWITCH_OPEN:
        assert property ($fell(sampleSwitchClosed)
            |-> $past(coreDone) || !converterActive)
        else $error("switch opened mid sample");
    AST_START_PULSE:
        assert property (coreStart |=> !coreStart)
        else $error("start pulse too long");
    // Ready rises only after a finished sample
    AST_READY_SET:
        assert property ($rose(resultReady) |-> $past(coreDone))
        else $error("ready without finished sample");
    // Ready falls only on a result read or a write of one
    AST_READY_CLEAR:
        assert property ($fell(resultReady)
            |-> $past(regRead && (regAddr == `ADCC_OFS_RESLO
            || regAddr == `ADCC_OFS_RESHI)) || $past(regWrite
            && regAddr == `ADCC_OFS_FLAGS && regWdata[0]))
        else $error("ready cleared without cause");
    // Partial sums never show; the result moves only on completion
    AST_RESULT_MOVE:
        assert property (!$stable(resultValue)
            |-> $past(coreDone) && resultReady)
        else $error("result changed outside completion");
endmodule

bind adcc_conversion_control adcc_conversion_control_chk
    adcc_conversion_control_chk_inst
(
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .coreDone(coreDone),
    .coreStart(coreStart), .sampleSwitchClosed(sampleSwitchClosed),
    .converterTick(converterTick), .converterActive(converterActive),
    .resultReady(resultReady), .resultValue(resultValue)
);
`default_nettype wire

// ==== tb/test_adcc_conversion_control.sv ====
// Self-checking bench of the converter control block
`timescale 1ns/1ps
`include "adcc_map.vh"
`default_nettype none
module test_adcc_conversion_control;
    // ==================================================================
    // Stimulus, observed outputs and bookkeeping
    logic        clk = 1'h0;
    logic        rst = 1'h1;
    logic [7:0]  regAddr = 8'h00;
    logic [7:0]  regWdata = 8'h00;
    logic        regWrite = 1'h0;
    logic        regRead = 1'h0;
    logic        standbySleep = 1'h0;
    logic        deepWake = 1'h0;
    logic [15:0] windowLow = 16'h0100;
    logic [15:0] windowHigh = 16'h0200;
    logic        coreDone = 1'h0;
    logic [9:0]  coreData = 10'h000;
    wire  [7:0]  regRdata;
    wire         coreStart, sampleSwitchClosed, converterTick;
    wire         converterActive, sampleCapReduced;
    wire         resultReady, windowMatch;
    wire  [1:0]  referenceSelect;
    wire  [15:0] resultValue;
    integer      miscompares = 0, n_tests = 0, cyc = 0, i, j, k, t;
    logic [7:0]  rv;
    logic [15:0] e;
    logic        m, swSeen;

    adcc_conversion_control adcc_conversion_control_inst
    (
        .clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .standbySleep(standbySleep), .deepWake(deepWake),
        .windowLow(windowLow), .windowHigh(windowHigh),
        .coreDone(coreDone), .coreData(coreData), .coreStart(coreStart),
        .sampleSwitchClosed(sampleSwitchClosed),
        .converterTick(converterTick), .converterActive(converterActive),
        .referenceSelect(referenceSelect),
        .sampleCapReduced(sampleCapReduced), .resultReady(resultReady),
        .windowMatch(windowMatch), .resultValue(resultValue)
    );

    // 10 MHz clock; the cycle ceiling cuts a hang short
    always #50 clk = ~clk;
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            miscompares = miscompares + 1;
            final_report;
        end
    end

    // ==================================================================
    // Shared tasks
    task check(input [15:0] seen, input [15:0] exp);
    begin
        n_tests = n_tests + 1;
        if (seen !== exp)
        begin
            miscompares = miscompares + 1;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    end
    endtask
    // Bus cycles: strobes last exactly one cycle
    task wr(input [7:0] a, input [7:0] d);
    begin
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'h1;
        @(posedge clk);
        regWrite <= 1'h0;
    end
    endtask
    task rd(input [7:0] a, output [7:0] d);
    begin
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'h1;
        @(posedge clk);
        regRead <= 1'h0;
        @(negedge clk);
        d = regRdata;
    end
    endtask
    task rdc(input [7:0] a, input [7:0] x);
    begin
        rd(a, rv);
        check(rv, x);
    end
    endtask
    task settle;
    begin
        repeat (2) @(posedge clk);
        #1;
    end
    endtask
    // Counts cycles to a start pulse (0) or a tick (1), noting the switch
    task waitfor(input sel);
    begin
        t = 0;
        swSeen = 1'h0;
        #1; // A start launched on the caller's last edge counts as t = 0
        while (((sel ? converterTick : coreStart) !== 1'h1
            || (sel && t == 0)) && t < 2000)
        begin
            @(posedge clk);
            #1;
            t = t + 1;
            swSeen = swSeen | (sampleSwitchClosed === 1'h1);
        end
    end
    endtask
    // One sample; stale data is inverted so it cannot pass by luck
    task sample(input [9:0] d);
    begin
        waitfor(1'h0);
        rdc(`ADCC_OFS_CMD, 8'h01);
        @(posedge clk);
        coreDone <= 1'h1;
        coreData <= d;
        @(posedge clk);
        coreDone <= 1'h0;
        coreData <= ~d;
    end
    endtask
    task conv(input [9:0] d, input integer n);
    begin
        wr(`ADCC_OFS_CMD, 8'h01);
        for (k = 0; k < n; k = k + 1)
        begin
            if (k == n - 1)
                check(resultReady, 1'h0);
            sample(d);
        end
        settle;
    end
    endtask
    // Start latency of n converter ticks at divide by two
    task lat(input integer n);
    begin
        wr(`ADCC_OFS_CMD, 8'h01);
        sample(10'h001);
        check(t + 1 >= 2 * n && t <= 2 * n + 3, 1'h1);
    end
    endtask

    // ==================================================================
    // Scenarios
    task t_regs;
    begin
        for (i = 0; i < 5; i = i + 1)
            wr(i[7:0], 8'hFF);
        wr(8'h07, 8'hFF);
        rdc(`ADCC_OFS_MAIN, `ADCC_MSK_MAIN);
        rdc(`ADCC_OFS_ACCUM, `ADCC_MSK_ACCUM);
        rdc(`ADCC_OFS_REFCLK, `ADCC_MSK_REFCLK);
        rdc(`ADCC_OFS_DELAY, `ADCC_MSK_DELAY);
        rdc(`ADCC_OFS_WINDOW, `ADCC_MSK_WINDOW);
        rdc(8'h07, 8'h00);
        @(posedge clk);
        rst <= 1'h1;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        for (i = 0; i < 5; i = i + 1)
            rdc(i[7:0], `ADCC_RST_CTRL);
        wr(`ADCC_OFS_REFCLK, 8'h50);
        settle;
        check({sampleCapReduced, referenceSelect}, 3'h5);
        wr(`ADCC_OFS_REFCLK, 8'h00);
        settle;
        check({sampleCapReduced, referenceSelect}, 3'h0);
        $display("test registers done");
    end
    endtask
    task t_res;
    begin
        wr(`ADCC_OFS_MAIN, 8'h01);
        conv(10'h3FF, 1);
        check(resultValue, 16'h03FF);
        wr(`ADCC_OFS_FLAGS, 8'h00);
        rdc(`ADCC_OFS_FLAGS, 8'h01);
        rdc(`ADCC_OFS_RESHI, 8'h03);
        rdc(`ADCC_OFS_FLAGS, 8'h00);
        rdc(`ADCC_OFS_CMD, 8'h00);
        wr(`ADCC_OFS_MAIN, 8'h05);
        conv(10'h3FF, 1);
        check(resultValue, 16'h00FF);
        wr(`ADCC_OFS_FLAGS, 8'h01);
        rdc(`ADCC_OFS_FLAGS, 8'h00);
        $display("test resolution done");
    end
    endtask
    task t_accum;
    begin
        wr(`ADCC_OFS_MAIN, 8'h01);
        for (i = 0; i < 8; i = i + 1)
        begin
            wr(`ADCC_OFS_ACCUM, i[7:0]);
            j = (i == 0 || i == 7) ? 1 : 1 << i;
            conv(10'h201, j);
            check(resultValue, 16'(j * 513));
            rd(`ADCC_OFS_RESLO, rv);
        end
        wr(`ADCC_OFS_ACCUM, 8'h00);
        $display("test accumulation done");
    end
    endtask
    task t_clk;
    begin
        for (i = 0; i < 8; i = i + 1)
        begin
            wr(`ADCC_OFS_REFCLK, i[7:0]);
            repeat (3) waitfor(1'h1);
            check(16'(t), 16'(2 << i));
        end
        wr(`ADCC_OFS_REFCLK, 8'h00);
        for (i = 0; i < 6; i = i + 1)
        begin
            wr(`ADCC_OFS_DELAY, {i[2:0], 5'h00});
            wr(`ADCC_OFS_MAIN, 8'h00);
            wr(`ADCC_OFS_MAIN, 8'h01);
            lat(i == 0 ? 0 : 8 << i);
        end
        lat(0);
        @(posedge clk);
        deepWake <= 1'h1;
        @(posedge clk);
        deepWake <= 1'h0;
        lat(256);
        wr(`ADCC_OFS_DELAY, 8'h20);
        wr(`ADCC_OFS_REFCLK, 8'h10);
        wr(`ADCC_OFS_REFCLK, 8'h00);
        lat(16);
        $display("test clocking done");
    end
    endtask
    task t_sdly;
    begin
        wr(`ADCC_OFS_DELAY, 8'h05);
        wr(`ADCC_OFS_ACCUM, 8'h01);
        wr(`ADCC_OFS_CMD, 8'h01);
        sample(10'h001);
        sample(10'h001);
        check(t + 1 >= 10 && t <= 13, 1'h1);
        check(swSeen, 1'h0);
        wr(`ADCC_OFS_ACCUM, 8'h00);
        wr(`ADCC_OFS_DELAY, 8'h1F);
        lat(0);
        rdc(`ADCC_OFS_DELAY, 8'h10);
        wr(`ADCC_OFS_DELAY, 8'h13);
        lat(0);
        rdc(`ADCC_OFS_DELAY, 8'h14);
        wr(`ADCC_OFS_DELAY, 8'h00);
        $display("test sampling delay done");
    end
    endtask
    task t_free;
    begin
        wr(`ADCC_OFS_MAIN, 8'h03);
        lat(0);
        sample(10'h010);
        check(t < 20, 1'h1);
        @(posedge clk);
        standbySleep <= 1'h1;
        settle;
        check(converterActive, 1'h0);
        wr(`ADCC_OFS_MAIN, 8'h83);
        settle;
        check(converterActive, 1'h1);
        wr(`ADCC_OFS_MAIN, 8'h00);
        standbySleep <= 1'h0;
        settle;
        check(converterActive, 1'h0);
        $display("test free running done");
    end
    endtask
    task t_win;
    begin
        wr(`ADCC_OFS_MAIN, 8'h01);
        for (i = 0; i < 8; i = i + 1)
            for (j = 0; j < 3; j = j + 1)
            begin
                e = 16'h0080 + 16'(j * 256);
                m = (i == 1 && e < 16'h0100) || (i == 2 && e > 16'h0200)
                    || (i == 3 && e == 16'h0180)
                    || (i == 4 && e != 16'h0180);
                wr(`ADCC_OFS_WINDOW, i[7:0]);
                wr(`ADCC_OFS_FLAGS, 8'h03);
                conv(e[9:0], 1);
                check(windowMatch, m);
            end
        $display("test window done");
    end
    endtask

    // Verdict; the only place the run ends
    task final_report;
    begin
        $display("compares %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask

    // Reset for 16 cycles, then every scenario in turn
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        t_regs;
        t_res;
        t_accum;
        t_clk;
        t_sdly;
        t_free;
        t_win;
        final_report;
    end
endmodule
`default_nettype wire
